// File: rtl/mc_config.sv
/*
 Memory controller configuration registers on AXI4-Lite, refresh timer,
 address and write-protect decode, timing decode and memory arbiter.
 Assumes requesters, access address and done pulses come from logic on i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mc_defs.svh"
module mc_config (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] i_acc_addr,
	input wire logic i_acc_write,
	output mc_pkg::mc_decode_s o_decode,
	output mc_pkg::mc_timing_s o_timing,
	input wire logic i_cpu_req,
	input wire logic i_internal_bus_req,
	input wire logic i_internal_bus_beat,
	input wire logic i_acc_done,
	output logic [2:0] o_grant,
	output logic o_refresh_req
);
	import mc_pkg::*;

	// ************************************************************
	// Register file and bus slave
	// ************************************************************
	logic [31:0] rom_mode_q, rom_access_timing_q, sdram_mode_q, sdram_geometry_q;
	logic [31:0] sdram_precharge_timing_q, refresh_reload_q, memory_arbiter_control_q;
	logic [15:0] refresh_count_now_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q, w_have_q;
	logic do_write;
	logic [31:0] wmerged;

	function automatic logic known(input logic [7:0] a);
		known = (a[1:0] == 2'b00) && (a <= `MC_OFS_ARB_CTRL);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	assign do_write = aw_have_q && w_have_q && !o_bvalid;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			aw_have_q <= 1'b0;
			waddr_q <= 8'h00;
		end else if (i_awvalid && o_awready) begin
			aw_have_q <= 1'b1;
			waddr_q <= i_awaddr;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			w_have_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (i_wvalid && o_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= i_wdata;
			wstrb_q <= i_wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end else begin
			o_awready <= !aw_have_q && !(i_awvalid && o_awready);
			o_wready <= !w_have_q && !(i_wvalid && o_wready);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp <= 2'b00;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			o_bresp <= known(waddr_q) ? 2'b00 : 2'b10;
		end else if (o_bready_take()) begin
			o_bvalid <= 1'b0;
		end
	end

	function automatic logic o_bready_take();
		o_bready_take = o_bvalid && i_bready;
	endfunction

	always_comb begin
		wmerged = 32'h0000_0000;
		unique case (waddr_q)
			`MC_OFS_ROM_MODE: wmerged = merge(rom_mode_q, wdata_q, wstrb_q);
			`MC_OFS_ROM_TIMING: wmerged = merge(rom_access_timing_q, wdata_q, wstrb_q);
			`MC_OFS_SD_MODE: wmerged = merge(sdram_mode_q, wdata_q, wstrb_q);
			`MC_OFS_SD_GEOM: wmerged = merge(sdram_geometry_q, wdata_q, wstrb_q);
			`MC_OFS_SD_PRECH: wmerged = merge(sdram_precharge_timing_q, wdata_q, wstrb_q);
			`MC_OFS_REF_RELOAD: wmerged = merge(refresh_reload_q, wdata_q, wstrb_q);
			`MC_OFS_ARB_CTRL: wmerged = merge(memory_arbiter_control_q, wdata_q, wstrb_q);
			default: wmerged = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rom_mode_q <= 32'h0000_0000;
			rom_access_timing_q <= 32'h0000_0000;
			sdram_mode_q <= `MC_RST_SD_MODE;
			sdram_geometry_q <= 32'h0000_0000;
			sdram_precharge_timing_q <= `MC_RST_SD_PRECH;
			refresh_reload_q <= {16'h0000, `MC_RST_REFRESH};
			memory_arbiter_control_q <= 32'h0000_0000;
		end else if (do_write) begin
			unique case (waddr_q)
				`MC_OFS_ROM_MODE: rom_mode_q <= wmerged & `MC_MASK_ROM_MODE;
				`MC_OFS_ROM_TIMING: rom_access_timing_q <= wmerged & `MC_MASK_ROM_TIMING;
				`MC_OFS_SD_MODE: sdram_mode_q <= wmerged & `MC_MASK_SD_MODE;
				`MC_OFS_SD_GEOM: sdram_geometry_q <= wmerged & `MC_MASK_SD_GEOM;
				`MC_OFS_SD_PRECH: sdram_precharge_timing_q <= wmerged & `MC_MASK_SD_PRECH;
				`MC_OFS_REF_RELOAD: begin
					if (wmerged[15:8] < `MC_REF_MIN_HI) begin
						refresh_reload_q <= {16'h0000, `MC_RST_REFRESH};
					end else begin
						refresh_reload_q <= wmerged & `MC_MASK_REF_RELOAD;
					end
				end
				`MC_OFS_ARB_CTRL: memory_arbiter_control_q <= wmerged & `MC_MASK_ARB_CTRL;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= 2'b00;
		end else begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp <= known(i_araddr) ? 2'b00 : 2'b10;
				unique case (i_araddr)
					`MC_OFS_ROM_MODE: o_rdata <= rom_mode_q;
					`MC_OFS_ROM_TIMING: o_rdata <= rom_access_timing_q;
					`MC_OFS_SD_MODE: o_rdata <= sdram_mode_q;
					`MC_OFS_SD_GEOM: o_rdata <= sdram_geometry_q;
					`MC_OFS_SD_PRECH: o_rdata <= sdram_precharge_timing_q;
					`MC_OFS_REF_RELOAD: o_rdata <= refresh_reload_q;
					`MC_OFS_REF_TIMER: o_rdata <= {16'h0000, refresh_count_now_q};
					`MC_OFS_ARB_CTRL: o_rdata <= memory_arbiter_control_q;
					default: o_rdata <= 32'h0000_0000;
				endcase
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Refresh timer
	// ************************************************************
	logic ref_expire;
	assign ref_expire = (refresh_count_now_q == 16'h0000);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			refresh_count_now_q <= `MC_RST_REFRESH;
		end else if (ref_expire) begin
			refresh_count_now_q <= refresh_reload_q[15:0];
		end else begin
			refresh_count_now_q <= refresh_count_now_q - 16'h0001;
		end
	end

	// ************************************************************
	// Timing decode
	// ************************************************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_timing <= '0;
		end else begin
			o_timing.rom_clks <= (rom_access_timing_q[2:0] == 3'h0) ? `MC_ROM_CLK_ZERO :
				{1'b0, rom_access_timing_q[2:0], 1'b0} + 5'h02;
			o_timing.ras_to_cas_delay <= (sdram_mode_q[9:8] == 2'h0) ? 3'h4 :
				{1'b0, sdram_mode_q[9:8]} + 3'h1;
			o_timing.cas_latency <= (sdram_mode_q[6:4] == 3'h2) ? 2'h2 : 2'h3;
			o_timing.active_to_precharge <= (sdram_precharge_timing_q[6:4] > 3'h4) ? 4'h8 :
				{1'b0, sdram_precharge_timing_q[6:4]} + 4'h4;
			o_timing.precharge_to_active <= (sdram_precharge_timing_q[1:0] == 2'h3) ? 3'h4 :
				{1'b0, sdram_precharge_timing_q[1:0]} + 3'h2;
			o_timing.write_to_precharge <= sdram_precharge_timing_q[8] ? 2'h2 : 2'h1;
			o_timing.column_addr_width <= {2'b00, sdram_geometry_q[1:0]} + 4'h7;
			o_timing.row_col_addr_width <= (sdram_geometry_q[6:4] > 3'h5) ? 5'h16 :
				{2'b00, sdram_geometry_q[6:4]} + 5'h11;
			o_timing.bank_count <= sdram_geometry_q[7];
		end
	end

	// ************************************************************
	// Address and write-protect decode
	// ************************************************************
	logic in_boot, in_ext, boot_ok, sd_ok;
	always_comb begin
		in_boot = (i_acc_addr >= `MC_BOOT_LO);
		in_ext = (i_acc_addr >= `MC_EXT_LO) && (i_acc_addr <= `MC_EXT_HI);
		unique case (rom_mode_q[1:0])
			2'b00: boot_ok = (i_acc_addr >= `MC_BOOT_BASE4);
			2'b01: boot_ok = 1'b1;
			2'b10: boot_ok = (i_acc_addr >= `MC_BOOT_BASE4) && (i_acc_addr <= `MC_BOOT_END1);
			2'b11: boot_ok = (i_acc_addr >= `MC_BOOT_BASE4) && (i_acc_addr <= `MC_BOOT_END2);
		endcase
		unique case (sdram_geometry_q[9:8])
			2'b00: sd_ok = (i_acc_addr[31:22] == 10'h000);
			2'b01: sd_ok = (i_acc_addr[31:23] == 9'h000);
			2'b10: sd_ok = (i_acc_addr[31:24] == 8'h00);
			2'b11: sd_ok = (i_acc_addr[31:25] == 7'h00);
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_decode <= '0;
		end else begin
			o_decode.sel_sdram <= sd_ok;
			o_decode.sel_boot <= in_boot && boot_ok;
			o_decode.sel_ext <= in_ext;
			o_decode.addr_err <= in_boot && !boot_ok;
			o_decode.wr_blocked <= i_acc_write && (in_boot || in_ext) && !rom_mode_q[8];
		end
	end

	// ************************************************************
	// Memory arbiter
	// ************************************************************
	mc_arb_e arb_q;
	logic [2:0] pend, grab;
	logic [1:0] age_q [3];
	logic [3:0] beat_q;
	logic ref_pend_q, cpu_pend_q, internal_bus_pend_q, fair, boundary;

	assign fair = memory_arbiter_control_q[0];
	assign pend = {internal_bus_pend_q, ref_pend_q, cpu_pend_q};
	assign boundary = i_internal_bus_beat && (beat_q == `MC_BURST_BOUND);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ref_pend_q <= 1'b0;
			cpu_pend_q <= 1'b0;
			internal_bus_pend_q <= 1'b0;
		end else begin
			ref_pend_q <= ref_expire || (ref_pend_q && !grab[1]);
			cpu_pend_q <= i_cpu_req && !grab[0];
			internal_bus_pend_q <= i_internal_bus_req && !grab[2];
		end
	end

	always_comb begin
		grab = 3'b000;
		if (fair) begin
			for (int i = 2; i >= 0; i--) begin
				if (pend[i] && (grab == 3'b000 || age_q[i] <= age_q[0] || i == 0)) begin
					grab = 3'b000;
				end
			end
			for (int i = 0; i < 3; i++) begin
				if (pend[i] && grab == 3'b000) begin
					grab[i] = 1'b1;
					for (int j = 0; j < 3; j++) begin
						if (pend[j] && age_q[j] > age_q[i]) begin
							grab = 3'b000;
						end
					end
				end
			end
			if (pend != 3'b000 && grab == 3'b000) begin
				grab = pend & ~(pend - 3'b001);
			end
			if (arb_q == MC_BUSY) begin
				grab = 3'b000;
			end
		end else if (arb_q == MC_IDLE) begin
			grab = pend & ~(pend - 3'b001);
		end else if (o_grant[2] && ref_pend_q) begin
			grab = 3'b010;
		end else if (o_grant[2] && cpu_pend_q && boundary) begin
			grab = 3'b001;
		end
	end

	generate
		for (genvar g = 0; g < 3; g++) begin : g_age
			always_ff @(posedge i_mclk or posedge i_rst) begin
				if (i_rst) begin
					age_q[g] <= 2'h0;
				end else if (!pend[g] || grab[g]) begin
					age_q[g] <= 2'h0;
				end else if (age_q[g] != 2'h3) begin
					age_q[g] <= age_q[g] + 2'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			beat_q <= 4'h0;
		end else if (grab != 3'b000) begin
			beat_q <= 4'h0;
		end else if (i_internal_bus_beat && o_grant[2]) begin
			beat_q <= beat_q + 4'h1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			arb_q <= MC_IDLE;
			o_grant <= 3'b000;
		end else if (grab != 3'b000) begin
			arb_q <= MC_BUSY;
			o_grant <= grab;
		end else if (i_acc_done) begin
			arb_q <= MC_IDLE;
			o_grant <= 3'b000;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_refresh_req <= 1'b0;
		end else begin
			o_refresh_req <= grab[1];
		end
	end
endmodule // mc_config
`default_nettype wire

// File: rtl/mc_defs.svh
/*
 Constants of the memory controller configuration block: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the top module.
*/
`ifndef MC_DEFS_SVH
`define MC_DEFS_SVH
`define MC_OFS_ROM_MODE 8'h00
`define MC_OFS_ROM_TIMING 8'h04
`define MC_OFS_SD_MODE 8'h08
`define MC_OFS_SD_GEOM 8'h0C
`define MC_OFS_SD_PRECH 8'h10
`define MC_OFS_REF_RELOAD 8'h14
`define MC_OFS_REF_TIMER 8'h18
`define MC_OFS_ARB_CTRL 8'h1C
`define MC_MASK_ROM_MODE 32'h0000_0103
`define MC_MASK_ROM_TIMING 32'h0000_0007
`define MC_MASK_SD_MODE 32'h0000_0377
`define MC_MASK_SD_GEOM 32'h0000_03F3
`define MC_MASK_SD_PRECH 32'h0000_0173
`define MC_MASK_REF_RELOAD 32'h0000_FF00
`define MC_MASK_ARB_CTRL 32'h0000_0001
`define MC_RST_SD_MODE 32'h0000_0330
`define MC_RST_SD_PRECH 32'h0000_0142
`define MC_RST_REFRESH 16'h0200
`define MC_REF_MIN_HI 8'h01
`define MC_BOOT_LO 32'h1F80_0000
`define MC_BOOT_BASE4 32'h1FC0_0000
`define MC_BOOT_END1 32'h1FCF_FFFF
`define MC_BOOT_END2 32'h1FDF_FFFF
`define MC_EXT_LO 32'h1F00_0000
`define MC_EXT_HI 32'h1F7F_FFFF
`define MC_ROM_CLK_ZERO 5'h12
`define MC_BURST_BOUND 4'hF
`endif

// File: rtl/mc_pkg.sv
/*
 Types of the memory controller configuration block.
 Assumes no other file; it does not use mc_defs.svh.
*/
package mc_pkg;
	typedef struct packed {
		logic [4:0] rom_clks;
		logic [2:0] ras_to_cas_delay;
		logic [1:0] cas_latency;
		logic [3:0] active_to_precharge;
		logic [2:0] precharge_to_active;
		logic [1:0] write_to_precharge;
		logic [3:0] column_addr_width;
		logic [4:0] row_col_addr_width;
		logic bank_count;
	} mc_timing_s;
	typedef struct packed {
		logic sel_sdram;
		logic sel_boot;
		logic sel_ext;
		logic addr_err;
		logic wr_blocked;
	} mc_decode_s;
	typedef enum logic [1:0] {
		MC_IDLE = 2'b01,
		MC_BUSY = 2'b10
	} mc_arb_e;
endpackage

// File: sim/mc_config_props.sv
/*
 Checker of the memory controller configuration block, bound to its top.
 Assumes mc_pkg is compiled first and one clock with an async reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mc_config_props (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] i_acc_addr,
	input wire logic i_acc_done,
	input wire mc_pkg::mc_decode_s o_decode,
	input wire mc_pkg::mc_timing_s o_timing,
	input wire logic [2:0] o_grant,
	input wire logic o_refresh_req
);
	import mc_pkg::*;
	logic up_q;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	// ********************************
	// Properties
	// ********************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			up_q <= 1'b0;
		end else begin
			up_q <= 1'b1;
		end
	end
	a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("Write response dropped early.");
	a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
		else $error("Read response dropped early.");
	a_grant_onehot: assert property ($onehot0(o_grant))
		else $error("More than one grant.");
	a_cpu_grant_hold: assert property (o_grant == 3'h1 && !i_acc_done |=> o_grant == 3'h1)
		else $error("CPU grant lost before done.");
	a_refresh_pulse: assert property (o_refresh_req |-> $rose(o_grant[1]) ##1 !o_refresh_req)
		else $error("Refresh request not tied to refresh grant.");
	a_ext_region: assert property (i_acc_addr inside {[32'h1F00_0000:32'h1F7F_FFFF]}
		|=> o_decode.sel_ext && !o_decode.addr_err && !o_decode.sel_boot)
		else $error("Extra region decode wrong.");
	a_sdram_base: assert property (i_acc_addr < 32'h0040_0000
		|=> o_decode.sel_sdram && !o_decode.addr_err)
		else $error("Low SDRAM decode wrong.");
	a_rom_clks: assert property (up_q |-> o_timing.rom_clks inside
		{5'h4, 5'h6, 5'h8, 5'hA, 5'hC, 5'hE, 5'h10, 5'h12})
		else $error("ROM cycle count out of set.");
	a_ras_cas_range: assert property (up_q |-> o_timing.ras_to_cas_delay inside {[3'h2:3'h4]})
		else $error("RAS to CAS delay out of range.");
	a_row_col_range: assert property (up_q |-> o_timing.row_col_addr_width inside {[5'h11:5'h16]})
		else $error("Row plus column width out of range.");
	c_refresh: cover property (o_refresh_req);
	c_internal_bus_grant: cover property ($rose(o_grant[2]));
	c_write_done: cover property (o_bvalid && i_bready);
endmodule // mc_config_props
bind mc_config mc_config_props u_props (.i_mclk, .i_rst, .o_bvalid, .i_bready, .o_rvalid,
	.i_rready, .i_acc_addr, .i_acc_done, .o_decode, .o_timing, .o_grant, .o_refresh_req);
`default_nettype wire

// File: sim/mc_mem_model.sv
/*
 Memory side model: ends each granted access after a set number of cycles.
 Assumes the grant vector of the block and the same clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mc_mem_model (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [2:0] i_grant,
	input wire logic [7:0] i_lat,
	output logic o_done
);
	logic [7:0] cnt_q;
	logic [2:0] gnt_q;
	// ********************************
	// Access timing
	// ********************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 8'h00;
			gnt_q <= 3'h0;
			o_done <= 1'b0;
		end else begin
			gnt_q <= i_grant;
			o_done <= 1'b0;
			if (i_grant == 3'h0 || i_grant != gnt_q || o_done) begin
				cnt_q <= 8'h00;
			end else if (cnt_q >= i_lat) begin
				o_done <= 1'b1;
				cnt_q <= 8'h00;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule // mc_mem_model
`default_nettype wire

// File: sim/test_memory_controller_config.sv
/*
 Self-checking bench of the memory controller configuration block.
 Assumes mc_pkg, the block, the memory model and the checker are compiled.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_memory_controller_config;
	import mc_pkg::*;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, acc_write, cpu_req, internal_bus_req, beat;
	logic awready, wready, bvalid, arready, rvalid, done, rfr;
	logic [7:0] awaddr, araddr, lat;
	logic [31:0] wdata, rdata, acc_addr;
	logic [1:0] bresp, rresp, last_resp;
	logic [2:0] grant;
	mc_pkg::mc_decode_s dec;
	mc_pkg::mc_timing_s tim;
	int n_fail, checks_done;
	// ********************************
	// Harness
	// ********************************
	mc_config uut (.i_mclk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_acc_addr(acc_addr),
		.i_acc_write(acc_write), .o_decode(dec), .o_timing(tim), .i_cpu_req(cpu_req),
		.i_internal_bus_req(internal_bus_req), .i_internal_bus_beat(beat), .i_acc_done(done), .o_grant(grant),
		.o_refresh_req(rfr));
	mc_mem_model u_mem (.i_mclk(clk), .i_rst(rst), .i_grant(grant), .i_lat(lat), .o_done(done));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge clk);
		last_resp = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk);
		d = rdata;
		last_resp = rresp;
	endtask
	task automatic probe(input logic [31:0] a);
		acc_addr <= a;
		repeat (2) @(posedge clk);
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_new(input logic [2:0] old, input logic [2:0] exp);
		do @(posedge clk); while (grant === old || grant === 3'h0);
		`CHK("grant", exp, grant);
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs();
		logic [31:0] v;
		logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
		logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h330, 32'h0, 32'h142, 32'h200, 32'h0};
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], v);
			`CHK("reset value", rv[i], v);
		end
		`CHK("reset ras_to_cas", 3'h4, tim.ras_to_cas_delay);
		`CHK("reset cas_latency", 2'h3, tim.cas_latency);
		`CHK("reset write_to_precharge", 2'h2, tim.write_to_precharge);
		`CHK("reset active_to_precharge", 4'h8, tim.active_to_precharge);
		`CHK("reset precharge_to_active", 3'h4, tim.precharge_to_active);
		wr(8'h00, 32'hFFFF_FF01);
		rd(8'h00, v);
		`CHK("rom_mode", 32'h101, v);
		wr(8'h14, 32'h0000_00FF);
		rd(8'h14, v);
		`CHK("reload small", 32'h200, v);
		wr(8'h14, 32'h0000_12AB);
		rd(8'h14, v);
		`CHK("reload low byte", 32'h1200, v);
		rd(8'h20, v);
		`CHK("unmapped resp", 2'h2, last_resp);
		wr(8'h20, 32'h0000_0001);
		`CHK("unmapped write resp", 2'h2, last_resp);
		$display("t_regs done");
	endtask
	task automatic t_timing();
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 32'(c));
			probe(32'h0);
			`CHK("rom_cycle_clocks", (c == 0) ? 5'h12 : 5'(2 * c + 2), tim.rom_clks);
		end
		wr(8'h08, 32'h0000_0120);
		wr(8'h10, 32'h0000_0000);
		wr(8'h0C, 32'h0000_03D3);
		probe(32'h01FF_FFFC);
		`CHK("ras_to_cas", 3'h2, tim.ras_to_cas_delay);
		`CHK("cas_latency", 2'h2, tim.cas_latency);
		`CHK("write_to_precharge", 2'h1, tim.write_to_precharge);
		`CHK("active_to_precharge", 4'h4, tim.active_to_precharge);
		`CHK("precharge_to_active", 3'h2, tim.precharge_to_active);
		`CHK("column_addr_width", 4'hA, tim.column_addr_width);
		`CHK("row_col_addr_width", 5'h16, tim.row_col_addr_width);
		`CHK("bank_count", 1'b1, tim.bank_count);
		`CHK("sdram top", 1'b1, dec.sel_sdram);
		$display("t_timing done");
	endtask
	task automatic t_boot();
		for (int c = 0; c < 4; c++) begin
			do_reset();
			wr(8'h00, {23'h0, c[0], 6'h0, c[1:0]});
			acc_write <= 1'b1;
			probe(32'h1FBF_FFFF);
			`CHK("err below 4M", c != 1, dec.addr_err);
			probe(32'h1FD0_0000);
			`CHK("err above 1M", c == 2, dec.addr_err);
			probe(32'h1FE0_0000);
			`CHK("err above 2M", c[1], dec.addr_err);
			probe(32'h1FC0_0000);
			`CHK("boot write block", !c[0], dec.wr_blocked);
			`CHK("boot select", 1'b1, dec.sel_boot);
			probe(32'h1F00_0000);
			`CHK("ext write block", !c[0], dec.wr_blocked);
			acc_write <= 1'b0;
		end
		$display("t_boot done");
	endtask
	task automatic t_refresh();
		int n;
		logic [31:0] v;
		wr(8'h14, 32'h0000_0100);
		rd(8'h18, v);
		`CHK("timer range", 1'b1, v <= 32'h200);
		do @(posedge clk); while (!rfr);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!rfr);
		`CHK("refresh period", 257, n);
		wr(8'h14, 32'h0000_FF00);
		do @(posedge clk); while (!rfr);
		$display("t_refresh done");
	endtask
	task automatic t_arb();
		while (grant !== 3'h0) @(posedge clk);
		lat <= 8'h3C;
		cpu_req <= 1'b1;
		internal_bus_req <= 1'b1;
		wait_new(3'h0, 3'h1);
		cpu_req <= 1'b0;
		wait_new(3'h1, 3'h4);
		internal_bus_req <= 1'b0;
		cpu_req <= 1'b1;
		beat <= 1'b1;
		repeat (15) @(posedge clk);
		`CHK("grant mid burst", 3'h4, grant);
		@(posedge clk);
		beat <= 1'b0;
		wait_new(3'h4, 3'h1);
		cpu_req <= 1'b0;
		lat <= 8'h02;
		while (grant !== 3'h0) @(posedge clk);
		wr(8'h1C, 32'h1);
		cpu_req <= 1'b1;
		internal_bus_req <= 1'b1;
		wait_new(3'h0, 3'h1);
		cpu_req <= 1'b0;
		wait_new(3'h1, 3'h4);
		internal_bus_req <= 1'b0;
		$display("t_arb done");
	endtask
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{acc_write, cpu_req, internal_bus_req, beat} = 4'h0;
		{awaddr, araddr, wdata, acc_addr} = 80'h0;
		lat = 8'h02;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_timing();
		t_boot();
		t_refresh();
		t_arb();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule // test_memory_controller_config
`default_nettype wire
